// [hw/uib_uart_core.sv]
// Serial core: bus registers, interrupt priority, baud divisor, FIFO control
//
// Function
// - While any enabled interrupt condition exists the ident register shows pending and source.
// - Priority runs line status, then data or timeout, then transmit empty, then modem status.
// - The baud generator divides the clock by any integer from 1 to 65535.
// - The generator output runs at sixteen times the bit rate and clocks both shifters.
// - The divisor is one 16-bit value held in a low-byte and a high-byte latch.
// - One-and-a-half stop bits at 5-bit words is not supported.
// - Write data and read data use two separate one-way byte paths.
// - FIFO control enables and clears the FIFOs, sets the trigger and the DMA style.
// - The scratch register returns whatever byte was last written.
// - The mask register gates each of the four sources before the interrupt output.
// - A start edge is checked again at mid start bit and dropped if the line is high.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module uib_uart_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_in_i,
    input wire logic [3:0] modem_n_i,
    output logic serial_out_o,
    output logic baud_x16_out_o,
    output logic irq_out_o,
    output logic tx_dma_req_n_o,
    output logic rx_dma_req_n_o
);
    // Decode helper shared by every register strobe
    function automatic logic hit(input logic strobe, input logic [7:0] adr,
                                 input logic [7:0] off);
        return strobe && (adr == off);
    endfunction

    // Bus handshake: ack one cycle after request, effects at the acked edge
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire bus_acc = bus_req & wb_ack_o;
    wire wr_acc = bus_acc & wb_we_i & wb_sel_i[0];
    wire rd_acc = bus_acc & ~wb_we_i;
    wire [7:0] wdat = wb_dat_i[7:0];
    wire wr_data = hit(wr_acc, wb_adr_i, uib_pkg::ADR_DATA);
    wire wr_mask = hit(wr_acc, wb_adr_i, uib_pkg::ADR_IRQ_MASK);
    wire wr_fifo = hit(wr_acc, wb_adr_i, uib_pkg::ADR_IDENT_FIFO);
    wire wr_lcr = hit(wr_acc, wb_adr_i, uib_pkg::ADR_LINE_CTRL);
    wire wr_scr = hit(wr_acc, wb_adr_i, uib_pkg::ADR_SCRATCH);
    wire wr_dlo = hit(wr_acc, wb_adr_i, uib_pkg::ADR_DIV_LO);
    wire wr_dhi = hit(wr_acc, wb_adr_i, uib_pkg::ADR_DIV_HI);
    wire rd_data = hit(rd_acc, wb_adr_i, uib_pkg::ADR_DATA);
    wire rd_ident = hit(rd_acc, wb_adr_i, uib_pkg::ADR_IDENT_FIFO);
    wire rd_lsr = hit(rd_acc, wb_adr_i, uib_pkg::ADR_LINE_STAT);
    wire rd_msr = hit(rd_acc, wb_adr_i, uib_pkg::ADR_MODEM_STAT);

    // Software registers
    logic [3:0] irq_mask_reg;
    uib_pkg::uib_fifo_cfg_t fifo_ctrl_reg;
    logic [2:0] line_ctrl;
    logic [7:0] scratch_byte_reg;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    wire [15:0] divisor = {div_hi, div_lo};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_reg <= 4'h0;
            fifo_ctrl_reg <= '0;
            line_ctrl <= 3'h0;
            scratch_byte_reg <= 8'h00;
            div_lo <= uib_pkg::DIV_LO_RST;
            div_hi <= uib_pkg::DIV_HI_RST;
        end else begin
            if (wr_mask) irq_mask_reg <= wdat[3:0];
            if (wr_fifo) fifo_ctrl_reg <= {wdat[uib_pkg::FCR_TRIG +: 2],
                wdat[uib_pkg::FCR_DMA], wdat[uib_pkg::FCR_EN]};
            if (wr_lcr) line_ctrl <= wdat[2:0];
            if (wr_scr) scratch_byte_reg <= wdat;
            if (wr_dlo) div_lo <= wdat;
            if (wr_dhi) div_hi <= wdat;
        end
    end

    // FIFO clear strobes act once and are not stored
    wire clr_rx = wr_fifo & wdat[uib_pkg::FCR_CLR_RX];
    wire clr_tx = wr_fifo & wdat[uib_pkg::FCR_CLR_TX];

    // Character length 5..8; stop bit select means two stops even at 5 bits
    wire [3:0] nbits = uib_pkg::WORD_MIN + {2'b00, line_ctrl[1:0]};
    wire two_stops = line_ctrl[uib_pkg::LCR_STOP2];

    // Baud tick doubles as the 16x sample enable for both shifters
    logic tick;
    uib_baud_gen u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .divisor_i(divisor),
        .tick_o(tick)
    );

    // Line inputs come from outside, so two flops before any use
    logic rx_meta;
    logic rx_line;
    logic [3:0] modem_meta;
    logic [3:0] modem_sync;
    logic [3:0] modem_prev;
    always_ff @(posedge clk_i) begin
        rx_meta <= serial_in_i;
        rx_line <= rx_meta;
        modem_meta <= modem_n_i;
        modem_sync <= modem_meta;
        modem_prev <= modem_sync;
    end

    // Receiver
    uib_pkg::uib_rx_state_t rx_state;
    logic [3:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_push;
    logic rx_frame_bad;
    wire rx_last_tick = tick && rx_cnt == uib_pkg::TICK_LAST;
    wire [7:0] rx_word = rx_shift >> (4'h8 - nbits);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state <= uib_pkg::RX_IDLE;
            rx_cnt <= 4'h0;
            rx_bit <= 4'h0;
            rx_shift <= 8'h00;
            rx_push <= 1'b0;
            rx_frame_bad <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            rx_frame_bad <= 1'b0;
            if (tick) rx_cnt <= rx_cnt + 4'h1;
            case (rx_state)
                uib_pkg::RX_IDLE: begin
                    rx_cnt <= 4'h0;
                    if (!rx_line) rx_state <= uib_pkg::RX_START;
                end
                uib_pkg::RX_START: begin
                    // Glitches shorter than half a bit never start a word
                    if (tick && rx_cnt == uib_pkg::TICK_MID) begin
                        rx_cnt <= 4'h0;
                        rx_bit <= 4'h0;
                        rx_state <= rx_line ? uib_pkg::RX_IDLE : uib_pkg::RX_DATA;
                    end
                end
                uib_pkg::RX_DATA: begin
                    if (rx_last_tick) begin
                        rx_shift <= {rx_line, rx_shift[7:1]};
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit == nbits - 4'h1) rx_state <= uib_pkg::RX_STOP;
                    end
                end
                uib_pkg::RX_STOP: begin
                    if (rx_last_tick) begin
                        rx_push <= 1'b1;
                        rx_frame_bad <= ~rx_line;
                        rx_state <= uib_pkg::RX_IDLE;
                    end
                end
                default: rx_state <= uib_pkg::RX_IDLE;
            endcase
        end
    end

    // Receive buffer; an unread pair makes the next word an overrun
    logic rx_ready;
    logic rx_avail;
    logic [7:0] rx_out;
    logic [1:0] rx_count;
    uib_buf2 #(.WIDTH(8)) u_rx_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(clr_rx),
        .in_valid_i(rx_push),
        .in_ready_o(rx_ready),
        .in_data_i(rx_word),
        .out_valid_o(rx_avail),
        .out_ready_i(rd_data),
        .out_data_o(rx_out),
        .count_o(rx_count)
    );

    // Transmitter: one holding byte feeding the shifter
    uib_pkg::uib_tx_state_t tx_state;
    logic [7:0] thr;
    logic thr_full;
    logic [7:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [3:0] tx_bit;
    logic tx_second;
    wire tx_load = (tx_state == uib_pkg::TX_IDLE) && thr_full;
    wire tx_last_tick = tick && tx_cnt == uib_pkg::TICK_LAST;

    // Writes while full are dropped; software waits for THRE
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_tx) begin
            thr_full <= 1'b0;
        end else if (wr_data && !thr_full) begin
            thr <= wdat;
            thr_full <= 1'b1;
        end else if (tx_load) begin
            thr_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state <= uib_pkg::TX_IDLE;
            tx_cnt <= 4'h0;
            tx_bit <= 4'h0;
            tx_shift <= 8'h00;
            tx_second <= 1'b0;
        end else begin
            if (tick) tx_cnt <= tx_cnt + 4'h1;
            case (tx_state)
                uib_pkg::TX_IDLE: begin
                    tx_cnt <= 4'h0;
                    tx_second <= 1'b0;
                    if (tx_load) begin
                        tx_shift <= thr;
                        tx_state <= uib_pkg::TX_START;
                    end
                end
                uib_pkg::TX_START: begin
                    if (tx_last_tick) begin
                        tx_bit <= 4'h0;
                        tx_state <= uib_pkg::TX_DATA;
                    end
                end
                uib_pkg::TX_DATA: begin
                    if (tx_last_tick) begin
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bit <= tx_bit + 4'h1;
                        if (tx_bit == nbits - 4'h1) tx_state <= uib_pkg::TX_STOP;
                    end
                end
                uib_pkg::TX_STOP: begin
                    if (tx_last_tick) begin
                        tx_second <= 1'b1;
                        if (!two_stops || tx_second) tx_state <= uib_pkg::TX_IDLE;
                    end
                end
                default: tx_state <= uib_pkg::TX_IDLE;
            endcase
        end
    end

    wire next_serial_out = (tx_state == uib_pkg::TX_START) ? 1'b0 :
                           (tx_state == uib_pkg::TX_DATA) ? tx_shift[0] : 1'b1;
    wire tx_empty = (tx_state == uib_pkg::TX_IDLE) && !thr_full;

    // Character timeout: data sitting untouched for four character times
    logic [9:0] tout_cnt;
    wire tout_hit = fifo_ctrl_reg.en && rx_avail && tout_cnt == uib_pkg::TOUT_TICKS;
    always_ff @(posedge clk_i) begin
        if (rst_i || rx_push || rd_data || !rx_avail) begin
            tout_cnt <= 10'h000;
        end else if (tick && !tout_hit) begin
            tout_cnt <= tout_cnt + 10'h001;
        end
    end

    // Sticky status; a new event in the clearing cycle wins over the clear
    logic overrun;
    logic framing;
    logic thre_irq;
    logic [3:0] modem_delta;
    wire ovr_set = rx_push & ~rx_ready;
    wire [3:0] delta_set = modem_sync ^ modem_prev;
    wire thre_clr = wr_data | (rd_ident && wb_dat_o[3:0] == uib_pkg::IID_THRE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overrun <= 1'b0;
            framing <= 1'b0;
            thre_irq <= 1'b1;
            modem_delta <= 4'h0;
        end else begin
            overrun <= ovr_set | (overrun & ~rd_lsr);
            framing <= rx_frame_bad | (framing & ~rd_lsr);
            thre_irq <= tx_load | (thre_irq & ~thre_clr);
            modem_delta <= delta_set | (modem_delta & {4{~rd_msr}});
        end
    end

    // Masked sources and their priority order
    wire [1:0] trig_lvl = (fifo_ctrl_reg.trig == 2'b00) ? 2'h1 : 2'h2;
    wire rx_level = fifo_ctrl_reg.en ? (rx_count >= trig_lvl) : rx_avail;
    wire pend_line = irq_mask_reg[uib_pkg::MSK_LINE] & (overrun | framing);
    wire pend_rx = irq_mask_reg[uib_pkg::MSK_SERIAL_IN] & (rx_level | tout_hit);
    wire pend_thre = irq_mask_reg[uib_pkg::MSK_THRE] & thre_irq;
    wire pend_modem = irq_mask_reg[uib_pkg::MSK_MODEM] & (|modem_delta);
    wire any_pend = pend_line | pend_rx | pend_thre | pend_modem;
    wire [3:0] iid = pend_line ? uib_pkg::IID_LINE :
                     pend_rx ? (rx_level ? uib_pkg::IID_SERIAL_IN : uib_pkg::IID_TIMEOUT) :
                     pend_thre ? uib_pkg::IID_THRE :
                     pend_modem ? uib_pkg::IID_MODEM : uib_pkg::IID_NONE;

    wire [7:0] line_stat = (8'(rx_avail) << uib_pkg::LSR_DR) |
                           (8'(overrun) << uib_pkg::LSR_OE) |
                           (8'(framing) << uib_pkg::LSR_FE) |
                           (8'(~thr_full) << uib_pkg::LSR_THRE) |
                           (8'(tx_empty) << uib_pkg::LSR_TEMT);

    // Read selection; unmapped offsets answer zero
    logic [7:0] rd_mux;
    always_comb begin
        case (wb_adr_i)
            uib_pkg::ADR_DATA: rd_mux = rx_out;
            uib_pkg::ADR_IRQ_MASK: rd_mux = {4'h0, irq_mask_reg};
            uib_pkg::ADR_IDENT_FIFO: rd_mux = {{2{fifo_ctrl_reg.en}}, 2'b00, iid};
            uib_pkg::ADR_LINE_CTRL: rd_mux = {5'h00, line_ctrl};
            uib_pkg::ADR_LINE_STAT: rd_mux = line_stat;
            uib_pkg::ADR_MODEM_STAT: rd_mux = {~modem_sync, modem_delta};
            uib_pkg::ADR_SCRATCH: rd_mux = scratch_byte_reg;
            uib_pkg::ADR_DIV_LO: rd_mux = div_lo;
            uib_pkg::ADR_DIV_HI: rd_mux = div_hi;
            default: rd_mux = 8'h00;
        endcase
    end

    // Bus answer, captured before the acked edge applies side effects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req && !wb_ack_o) wb_dat_o <= {24'h00_0000, rd_mux};
        end
    end

    // Pin outputs, all registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_o <= 1'b1;
            baud_x16_out_o <= 1'b0;
            irq_out_o <= 1'b0;
            tx_dma_req_n_o <= 1'b1;
            rx_dma_req_n_o <= 1'b1;
        end else begin
            serial_out_o <= next_serial_out;
            baud_x16_out_o <= tick;
            irq_out_o <= any_pend;
            tx_dma_req_n_o <= thr_full;
            rx_dma_req_n_o <= ~(fifo_ctrl_reg.dma ? (rx_level | tout_hit) : rx_avail);
        end
    end

    chk_ident_shows_pending: assert property (@(posedge clk_i) disable iff (rst_i)
        any_pend |-> (iid[0] == 1'b0 && wb_adr_i != uib_pkg::ADR_IDENT_FIFO
                      || rd_mux[0] == 1'b0))
        else $error("pending source not reported");
    chk_line_first: assert property (@(posedge clk_i) disable iff (rst_i)
        pend_line |-> iid == uib_pkg::IID_LINE)
        else $error("line status not top priority");
    chk_modem_last: assert property (@(posedge clk_i) disable iff (rst_i)
        (pend_modem && (pend_rx || pend_thre)) |-> iid != uib_pkg::IID_MODEM)
        else $error("modem status outranked a higher source");
    chk_tx_bit_time: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_state == uib_pkg::TX_START && !tx_last_tick) |=> tx_state == uib_pkg::TX_START)
        else $error("start bit left before sixteen ticks");
    chk_div_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_dhi && !wr_dlo) |=> divisor[15:8] == $past(wdat) && $stable(div_lo))
        else $error("high divisor byte not latched");
    chk_fifo_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_rx |=> rx_count == 2'h0 && !rx_avail)
        else $error("receive buffer not cleared");
    chk_scratch_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && !wb_ack_o && !wb_we_i && wb_adr_i == uib_pkg::ADR_SCRATCH)
        |=> wb_dat_o[7:0] == scratch_byte_reg)
        else $error("scratch read mismatch");
    chk_false_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_state == uib_pkg::RX_START && tick && rx_cnt == uib_pkg::TICK_MID && rx_line)
        |=> rx_state == uib_pkg::RX_IDLE)
        else $error("false start not discarded");
    chk_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        any_pend[*2] |=> irq_out_o)
        else $error("interrupt dropped while source pending");
    chk_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        (irq_mask_reg == 4'h0) |=> !irq_out_o)
        else $error("masked source reached interrupt output");
endmodule

// [hw/uib_pkg.sv]
// Shared constants and types of the serial core with interrupt, baud and FIFO control
package uib_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] ADR_DATA = 8'h00;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h04;
    localparam logic [7:0] ADR_IDENT_FIFO = 8'h08;
    localparam logic [7:0] ADR_LINE_CTRL = 8'h0c;
    localparam logic [7:0] ADR_LINE_STAT = 8'h10;
    localparam logic [7:0] ADR_MODEM_STAT = 8'h14;
    localparam logic [7:0] ADR_SCRATCH = 8'h18;
    localparam logic [7:0] ADR_DIV_LO = 8'h1c;
    localparam logic [7:0] ADR_DIV_HI = 8'h20;
    // Interrupt mask bits
    localparam int MSK_SERIAL_IN = 0;
    localparam int MSK_THRE = 1;
    localparam int MSK_LINE = 2;
    localparam int MSK_MODEM = 3;
    // Identification codes, bit 0 low means pending
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_LINE = 4'h6;
    localparam logic [3:0] IID_SERIAL_IN = 4'h4;
    localparam logic [3:0] IID_TIMEOUT = 4'hc;
    localparam logic [3:0] IID_THRE = 4'h2;
    localparam logic [3:0] IID_MODEM = 4'h0;
    // FIFO control field positions
    localparam int FCR_EN = 0;
    localparam int FCR_CLR_RX = 1;
    localparam int FCR_CLR_TX = 2;
    localparam int FCR_DMA = 3;
    localparam int FCR_TRIG = 6;
    // Line control field positions
    localparam int LCR_STOP2 = 2;
    // Line status field positions
    localparam int LSR_DR = 0;
    localparam int LSR_OE = 1;
    localparam int LSR_FE = 3;
    localparam int LSR_THRE = 5;
    localparam int LSR_TEMT = 6;
    // Reset values
    localparam logic [7:0] DIV_LO_RST = 8'h01;
    localparam logic [7:0] DIV_HI_RST = 8'h00;
    // Timing in 16x ticks, and the shortest word length in bits
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] WORD_MIN = 4'h5;
    localparam logic [9:0] TOUT_TICKS = 10'h280;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} uib_rx_state_t;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} uib_tx_state_t;
    typedef struct packed {
        logic [1:0] trig;
        logic dma;
        logic en;
    } uib_fifo_cfg_t;
endpackage

// [hw/uib_baud_gen.sv]
// Programmable divider producing the 16x sampling tick
`timescale 1ns/1ps
module uib_baud_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] divisor_i,
    output logic tick_o
);
    logic [15:0] cnt;
    wire [15:0] last = divisor_i - 16'h0001;

    // Divisor of zero stops the tick rather than wrapping
    always_ff @(posedge clk_i) begin
        if (rst_i || divisor_i == 16'h0000) begin
            cnt <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt >= last) begin
            cnt <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            tick_o <= 1'b0;
        end
    end

    // Helper: cycles since last tick, valid only while divisor is steady
    logic [15:0] gap;
    logic gap_ok;
    always_ff @(posedge clk_i) begin
        gap <= tick_o ? 16'h0001 : gap + 16'h0001;
        gap_ok <= rst_i ? 1'b0 : ((tick_o || gap_ok) && divisor_i == $past(divisor_i));
    end

    chk_baud_period: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick_o && gap_ok && divisor_i != 16'h0000 && divisor_i == $past(divisor_i))
        |-> gap == divisor_i)
        else $error("baud tick period differs from divisor");
endmodule

// [hw/uib_buf2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module uib_buf2 #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [1:0] count_o
);
    logic [WIDTH-1:0] mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    // Honest flags straight from the fill count
    assign in_ready_o = (count_o != 2'h2);
    assign out_valid_o = (count_o != 2'h0);
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count_o <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count_o <= count_o + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// [verif/uib_line_model.sv]
// Far-end serial peer that frames bytes onto the receive line
`timescale 1ns/1ps
module uib_line_model (
    input wire logic clk_i,
    input wire logic serial_i,
    output logic serial_o,
    output logic [3:0] modem_n_o
);
    // Idle line high, modem lines inactive
    initial begin
        serial_o = 1'b1;
        modem_n_o = 4'hf;
    end
    // Start, eight data bits LSB first, one stop
    task automatic send(input logic [7:0] b, input int bit_cyc);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            serial_o <= fr[i];
            repeat (bit_cyc - 1) @(posedge clk_i);
        end
    endtask
    // Short low pulse, too brief to survive the mid-bit recheck
    task automatic glitch(input int len);
        @(posedge clk_i);
        serial_o <= 1'b0;
        repeat (len) @(posedge clk_i);
        serial_o <= 1'b1;
    endtask
    // Catch one 8-bit word from the core, sampling each bit at its centre
    task automatic recv(output logic [7:0] b, input int bit_cyc);
        @(posedge clk_i iff serial_i === 1'b0);
        repeat (bit_cyc / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk_i);
            b[i] = serial_i;
        end
    endtask
    // Move the modem lines just after an edge
    task automatic modem(input logic [3:0] v);
        @(posedge clk_i);
        modem_n_o <= v;
    endtask
endmodule

// [verif/test_uib_uart_core.sv]
// Bench for the serial core: scratch, divisor, interrupts, FIFO control
`timescale 1ns/1ps
module test_uib_uart_core;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0;
    logic [7:0] adr = 0, sb, rb, tx_seen;
    logic [31:0] wdat = 0, rdat;
    logic ack, sout, baud, irq, txn, rxn, ser;
    logic [3:0] mdm;
    logic [23:0] notes[$], note;
    int failures = 0, total_checks = 0, ticks = 0, n;
    always #5 clk_i = ~clk_i;
    uib_line_model peer (.clk_i(clk_i), .serial_i(sout), .serial_o(ser), .modem_n_o(mdm));
    uib_uart_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .serial_in_i(ser), .modem_n_i(mdm), .serial_out_o(sout),
        .baud_x16_out_o(baud), .irq_out_o(irq), .tx_dma_req_n_o(txn), .rx_dma_req_n_o(rxn));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One classic cycle; released only at the edge that sees ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // Only the hang guard ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    // Note the expectation first, the monitor compares on ack
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        notes.push_back({a, m, e});
        bus(1'b0, a, 8'h00);
    endtask
    // Oldest note against each read answer
    always @(posedge clk_i) begin
        if (cyc === 1'b1 && ack === 1'b1 && we === 1'b0) begin
            note = notes.pop_front();
            chk($sformatf("reg %h", note[23:16]), rdat[7:0] & note[15:8], note[7:0]);
        end
    end
    // Hang guard, well above the expected run length
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 10000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h88629635));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        sb = 8'($urandom());
        wr(uib_pkg::ADR_SCRATCH, sb);
        rd(uib_pkg::ADR_SCRATCH, sb);
        rd(8'hfc, 8'h00);
        $display("test scratch done");
        // Divisor 3 keeps frames short: 48 cycles per bit
        wr(uib_pkg::ADR_DIV_LO, 8'h03);
        wr(uib_pkg::ADR_DIV_HI, 8'h00);
        rd(uib_pkg::ADR_DIV_LO, 8'h03);
        rd(uib_pkg::ADR_DIV_HI, 8'h00);
        @(posedge clk_i iff baud === 1'b1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (baud !== 1'b1 && n < 9);
        chk("baud period", 8'(n), 8'h03);
        $display("test divisor done");
        wr(uib_pkg::ADR_LINE_CTRL, 8'h03);
        chk("irq masked", {7'h0, irq}, 8'h00);
        wr(uib_pkg::ADR_IRQ_MASK, 8'h02);
        repeat (3) @(posedge clk_i);
        chk("irq thre", {7'h0, irq}, 8'h01);
        rd(uib_pkg::ADR_IDENT_FIFO, 8'h02);
        // Data write re-arms empty; a received byte must outrank it
        wr(uib_pkg::ADR_IRQ_MASK, 8'h03);
        wr(uib_pkg::ADR_DATA, 8'h5a);
        rb = 8'($urandom());
        // Peer sends while it also catches the byte just written
        fork
            peer.send(rb, 48);
            peer.recv(tx_seen, 48);
        join
        chk("tx data", tx_seen, 8'h5a);
        repeat (4) @(posedge clk_i);
        chk("rx dma", {7'h0, rxn}, 8'h00);
        rd(uib_pkg::ADR_IDENT_FIFO, 8'h04);
        rd(uib_pkg::ADR_DATA, rb);
        rd(uib_pkg::ADR_IDENT_FIFO, 8'h02);
        $display("test priority done");
        peer.glitch(10);
        repeat (520) @(posedge clk_i);
        rd(uib_pkg::ADR_LINE_STAT, 8'h00, 8'h01);
        $display("test false start done");
        // FIFO enable shows in ident; clear empties received data
        wr(uib_pkg::ADR_IDENT_FIFO, 8'h01);
        rd(uib_pkg::ADR_IDENT_FIFO, 8'hc1);
        chk("irq idle", {7'h0, irq}, 8'h00);
        peer.send(rb, 48);
        repeat (4) @(posedge clk_i);
        wr(uib_pkg::ADR_IDENT_FIFO, 8'h03);
        rd(uib_pkg::ADR_LINE_STAT, 8'h00, 8'h01);
        chk("tx dma", {7'h0, txn}, 8'h00);
        $display("test fifo done");
        // Modem change alone, lowest source, still raises and names itself
        wr(uib_pkg::ADR_IRQ_MASK, 8'h08);
        peer.modem(4'he);
        repeat (5) @(posedge clk_i);
        chk("irq modem", {7'h0, irq}, 8'h01);
        rd(uib_pkg::ADR_IDENT_FIFO, 8'hc0);
        $display("test modem done");
        summarize();
    end
endmodule
